// file: adc_ctrl_defs.vh
/*
 * register offsets, field positions, codes and timing counts for the
 * converter channel and reference control block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef ADC_CTRL_DEFS_VH
`define ADC_CTRL_DEFS_VH

// byte offsets on apb (printed offsets are not all multiples of four)
`define IDX_CTRL_STATUS_A 8'h06
`define IDX_MUX_SELECT 8'h07
`define ADDR_CTRL_STATUS_A 12'h018
`define ADDR_MUX_SELECT 12'h01c
`define ADDR_RESULT 12'h020

// reset values
`define RST_CTRL_STATUS_A 8'h00
`define RST_MUX_SELECT 8'h00

// control/status a field positions
`define BIT_ENABLE 7
`define BIT_START 6
`define BIT_AUTO_TRIG 5
`define BIT_DONE 4
`define BIT_IRQ_EN 3

// reference select codes
`define REF_SUPPLY 2'h0
`define REF_EXTERNAL 2'h1
`define REF_INTERNAL 2'h2
`define REF_RESERVED 2'h3

// channel codes
`define CH_GROUND 6'h20
`define CH_BANDGAP 6'h21
`define CH_TEMP 6'h22
`define CH_CAL0 6'h23
`define CH_CAL3_LO 6'h24
`define CH_CAL3_HI 6'h25
`define CH_CAL7_LO 6'h26
`define CH_CAL7_HI 6'h27

// input selector codes on the analog side
`define SEL_NONE 4'hf
`define SEL_GROUND 4'h8
`define SEL_BANDGAP 4'h9
`define SEL_TEMP 4'ha

// conversion lengths in converter clock cycles
`define CONV_CYCLES_FIRST 5'd25
`define CONV_CYCLES_NORMAL 5'd13

`endif

// file: adc_mux_decode.v
/*
 * combinational decode of the channel/gain code into the positive and
 * negative input selections, gain and sensor enable.
 * assumes the code is the applied (not pending) channel code.
 */
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"

module adc_mux_decode (
    input wire [5:0] code,
    output reg [3:0] pos_sel,
    output reg [3:0] neg_sel,
    output reg differential,
    output reg gain_20x,
    output reg temp_enable
);

    // positive input of a normal pair, indexed by code[4:1]
    function [3:0] pair_pos;
        input [3:0] idx;
        begin
            case (idx)
                4'h4, 4'h5: pair_pos = 4'h0;
                4'h6, 4'h7: pair_pos = 4'h1;
                4'h8: pair_pos = 4'h2;
                4'h9, 4'ha, 4'hb, 4'hc: pair_pos = 4'h3;
                4'hd: pair_pos = 4'h4;
                4'he: pair_pos = 4'h5;
                4'hf: pair_pos = 4'h6;
                default: pair_pos = `SEL_NONE;
            endcase
        end
    endfunction

    // negative input of a normal pair, indexed by code[4:1]
    function [3:0] pair_neg;
        input [3:0] idx;
        begin
            case (idx)
                4'h4: pair_neg = 4'h1;
                4'h5, 4'h7, 4'h8: pair_neg = 4'h3;
                4'h6: pair_neg = 4'h2;
                4'h9: pair_neg = 4'h4;
                4'ha: pair_neg = 4'h5;
                4'hb: pair_neg = 4'h6;
                4'hc, 4'hf: pair_neg = 4'h7;
                4'hd: pair_neg = 4'h5;
                4'he: pair_neg = 4'h6;
                default: pair_neg = `SEL_NONE;
            endcase
        end
    endfunction

    // full decode of the six-bit code
    always @* begin
        pos_sel = `SEL_NONE;
        neg_sel = `SEL_NONE;
        differential = 1'b0;
        gain_20x = 1'b0;
        temp_enable = 1'b0;
        if (code[5:3] == 3'b000) begin
            // single-ended inputs 0..7
            pos_sel = {1'b0, code[2:0]};
        end else if (code[5] == 1'b0 || code[4:3] != 2'b00) begin
            // differential pair, top bit swaps polarity
            differential = 1'b1;
            gain_20x = code[0];
            if (code[5]) begin
                pos_sel = pair_neg(code[4:1]);
                neg_sel = pair_pos(code[4:1]);
            end else begin
                pos_sel = pair_pos(code[4:1]);
                neg_sel = pair_neg(code[4:1]);
            end
        end else begin
            case (code)
                `CH_GROUND: pos_sel = `SEL_GROUND;
                `CH_BANDGAP: pos_sel = `SEL_BANDGAP;
                `CH_TEMP: begin
                    pos_sel = `SEL_TEMP;
                    temp_enable = 1'b1;
                end
                `CH_CAL0: begin
                    // same pin both sides, 20x only
                    differential = 1'b1;
                    gain_20x = 1'b1;
                    pos_sel = 4'h0;
                    neg_sel = 4'h0;
                end
                `CH_CAL3_LO, `CH_CAL3_HI: begin
                    differential = 1'b1;
                    gain_20x = code[0];
                    pos_sel = 4'h3;
                    neg_sel = 4'h3;
                end
                `CH_CAL7_LO, `CH_CAL7_HI: begin
                    differential = 1'b1;
                    gain_20x = code[0];
                    pos_sel = 4'h7;
                    neg_sel = 4'h7;
                end
                default: pos_sel = `SEL_NONE;
            endcase
        end
    end

endmodule

// file: adc_channel_reference_control.v
/*
 * converter control: apb registers, reference and channel selection
 * with hold during conversion, enable, start, done flag and prescaler.
 * assumes an analog core that finishes a conversion when told and takes
 * its result from CONV_RESULT; one 10 mhz clock, synchronous reset.
 */
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"

module adc_channel_reference_control (
    input wire CLOCK,
    input wire SYS_RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output wire PREADY,
    output reg [31:0] PRDATA,
    output wire PSLVERR,
    input wire [9:0] CONV_RESULT,
    input wire IRQ_VECTOR_ACK,
    output reg CONVERTER_POWER,
    output reg CONVERTING,
    output reg SAMPLE_STROBE,
    output reg [1:0] REF_APPLIED,
    output reg REF_SUPPLY_SEL,
    output reg REF_EXTERNAL_SEL,
    output reg REF_INTERNAL_SEL,
    output reg REF_TO_PIN,
    output reg [3:0] POS_INPUT,
    output reg [3:0] NEG_INPUT,
    output reg DIFFERENTIAL,
    output reg GAIN_20X,
    output reg TEMP_SENSOR_EN,
    output reg DONE_IRQ
);

    reg [7:0] mux_select; // software view of the mux register
    reg [5:0] chan_applied; // code in force on the front end
    reg converter_enable; // power / enable bit
    reg conversion_start_bit; // busy bit, reads one while running
    reg auto_trigger_enable; // stored only
    reg conversion_done_flag; // sticky completion flag
    reg conversion_irq_enable; // gates done flag onto irq line
    reg [2:0] converter_clock_divider; // prescaler select
    reg [9:0] result; // last finished conversion
    reg first_pending; // next conversion is the long one
    reg [6:0] prescale_count; // system clock divider
    reg [4:0] cycle_count; // converter clocks left in conversion
    wire adc_tick; // one-cycle converter clock enable
    wire [3:0] dec_pos; // decoded positive input
    wire [3:0] dec_neg; // decoded negative input
    wire dec_diff; // decoded differential flag
    wire dec_gain; // decoded gain
    wire dec_temp; // decoded sensor enable
    wire wr_access; // apb write taken this edge
    wire wr_csra; // write to control/status a
    wire wr_mux; // write to mux register
    wire finish; // conversion completes this cycle
    wire start_req; // software start request
    wire [7:0] csra_read; // read view of control/status a

    // division factor minus one from the prescaler select
    function [6:0] div_limit;
        input [2:0] sel;
        begin
            case (sel)
                3'h0, 3'h1: div_limit = 7'h01;
                3'h2: div_limit = 7'h03;
                3'h3: div_limit = 7'h07;
                3'h4: div_limit = 7'h0f;
                3'h5: div_limit = 7'h1f;
                3'h6: div_limit = 7'h3f;
                default: div_limit = 7'h7f;
            endcase
        end
    endfunction

    // apb: zero wait states, never errors
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign wr_access = PSEL & PENABLE & PWRITE;
    assign wr_csra = wr_access & (PADDR == `ADDR_CTRL_STATUS_A);
    assign wr_mux = wr_access & (PADDR == `ADDR_MUX_SELECT);
    assign start_req = wr_csra & PWDATA[`BIT_START] & PWDATA[`BIT_ENABLE];
    assign finish = conversion_start_bit & adc_tick & (cycle_count == 5'd1);
    assign adc_tick = (prescale_count == div_limit(converter_clock_divider));

    assign csra_read = {converter_enable, conversion_start_bit,
        auto_trigger_enable, conversion_done_flag, conversion_irq_enable,
        converter_clock_divider};

    // read data mux, unmapped addresses read zero
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                `ADDR_CTRL_STATUS_A: PRDATA <= {24'h000000, csra_read};
                `ADDR_MUX_SELECT: PRDATA <= {24'h000000, mux_select};
                `ADDR_RESULT: PRDATA <= {22'h000000, result};
                default: PRDATA <= 32'h00000000;
            endcase
        end
    end

    // mux register and applied selections
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            mux_select <= `RST_MUX_SELECT;
            chan_applied <= 6'h00;
            REF_APPLIED <= `REF_SUPPLY;
        end else begin
            if (wr_mux) begin
                mux_select <= PWDATA[7:0]; // stored unchanged
            end
            if (!conversion_start_bit) begin
                // idle: take effect at once
                chan_applied <= wr_mux ? PWDATA[5:0] : mux_select[5:0];
                REF_APPLIED <= wr_mux ? PWDATA[7:6] : mux_select[7:6];
            end else if (finish || !converter_enable) begin
                // pending values applied at completion
                chan_applied <= wr_mux ? PWDATA[5:0] : mux_select[5:0];
                REF_APPLIED <= wr_mux ? PWDATA[7:6] : mux_select[7:6];
            end
        end
    end

    // control/status a and the conversion sequencer
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            converter_enable <= 1'b0;
            conversion_start_bit <= 1'b0;
            auto_trigger_enable <= 1'b0;
            conversion_done_flag <= 1'b0;
            conversion_irq_enable <= 1'b0;
            converter_clock_divider <= 3'h0;
            first_pending <= 1'b0;
            cycle_count <= 5'd0;
            result <= 10'h000;
        end else begin
            if (wr_csra) begin
                converter_enable <= PWDATA[`BIT_ENABLE];
                auto_trigger_enable <= PWDATA[`BIT_AUTO_TRIG];
                conversion_irq_enable <= PWDATA[`BIT_IRQ_EN];
                converter_clock_divider <= PWDATA[2:0];
            end
            if (wr_csra && PWDATA[`BIT_ENABLE] && !converter_enable) begin
                first_pending <= 1'b1; // next run initialises
            end
            if (wr_csra && !PWDATA[`BIT_ENABLE]) begin
                // abort with no result
                conversion_start_bit <= 1'b0;
                cycle_count <= 5'd0;
            end else if (start_req && !conversion_start_bit) begin
                // long first conversion after enabling
                conversion_start_bit <= 1'b1;
                first_pending <= 1'b0;
                cycle_count <= (first_pending || !converter_enable) ?
                    `CONV_CYCLES_FIRST : `CONV_CYCLES_NORMAL;
            end else if (conversion_start_bit && adc_tick) begin
                cycle_count <= cycle_count - 5'd1;
                if (finish) begin
                    conversion_start_bit <= 1'b0;
                    result <= CONV_RESULT;
                end
            end
            // set wins over clear
            if (finish && !(wr_csra && !PWDATA[`BIT_ENABLE])) begin
                conversion_done_flag <= 1'b1;
            end else if ((wr_csra && PWDATA[`BIT_DONE]) || IRQ_VECTOR_ACK) begin
                conversion_done_flag <= 1'b0;
            end
        end
    end

    // prescaler, runs only while enabled
    always @(posedge CLOCK) begin
        if (SYS_RST || !converter_enable || adc_tick) begin
            prescale_count <= 7'h00;
        end else begin
            prescale_count <= prescale_count + 7'h01;
        end
    end

    adc_mux_decode u_decode (
        .code(chan_applied),
        .pos_sel(dec_pos),
        .neg_sel(dec_neg),
        .differential(dec_diff),
        .gain_20x(dec_gain),
        .temp_enable(dec_temp)
    );

    // registered front-end controls
    always @(posedge CLOCK) begin
        if (SYS_RST) begin
            CONVERTER_POWER <= 1'b0;
            CONVERTING <= 1'b0;
            SAMPLE_STROBE <= 1'b0;
            REF_SUPPLY_SEL <= 1'b0;
            REF_EXTERNAL_SEL <= 1'b0;
            REF_INTERNAL_SEL <= 1'b0;
            REF_TO_PIN <= 1'b0;
            POS_INPUT <= `SEL_NONE;
            NEG_INPUT <= `SEL_NONE;
            DIFFERENTIAL <= 1'b0;
            GAIN_20X <= 1'b0;
            TEMP_SENSOR_EN <= 1'b0;
            DONE_IRQ <= 1'b0;
        end else begin
            CONVERTER_POWER <= converter_enable;
            CONVERTING <= conversion_start_bit;
            SAMPLE_STROBE <= finish;
            // reference decode, reserved selects no source and drives REF_TO_PIN
            REF_SUPPLY_SEL <= (REF_APPLIED == `REF_SUPPLY);
            REF_EXTERNAL_SEL <= (REF_APPLIED == `REF_EXTERNAL);
            REF_INTERNAL_SEL <= (REF_APPLIED == `REF_INTERNAL);
            REF_TO_PIN <= (REF_APPLIED == `REF_RESERVED);
            POS_INPUT <= dec_pos;
            NEG_INPUT <= dec_neg;
            DIFFERENTIAL <= dec_diff;
            GAIN_20X <= dec_gain;
            TEMP_SENSOR_EN <= dec_temp;
            DONE_IRQ <= conversion_done_flag & conversion_irq_enable;
        end
    end

endmodule

// file: adc_ctrl_sva.sv
/*
 * checker for the converter control block, bound to its top module.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module adc_ctrl_sva (
    input wire CLOCK,
    input wire SYS_RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire IRQ_VECTOR_ACK,
    input wire CONVERTER_POWER,
    input wire CONVERTING,
    input wire SAMPLE_STROBE,
    input wire [1:0] REF_APPLIED,
    input wire REF_SUPPLY_SEL,
    input wire REF_EXTERNAL_SEL,
    input wire REF_INTERNAL_SEL,
    input wire REF_TO_PIN,
    input wire [3:0] POS_INPUT,
    input wire DONE_IRQ
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    // completed write to control/status a
    wire wr_ctrl = PSEL && PENABLE && PWRITE && (PADDR == 12'h018);
    // cycles spent converting so far
    reg [11:0] conv_len;
    // count up while converting, clear otherwise
    always @(posedge CLOCK) begin
        if (SYS_RST || !CONVERTING) begin
            conv_len <= 12'h000;
        end else begin
            conv_len <= conv_len + 12'h001;
        end
    end
    property p_ref_decode;
        !$past(SYS_RST) |-> {REF_SUPPLY_SEL, REF_EXTERNAL_SEL,
            REF_INTERNAL_SEL} == {$past(REF_APPLIED) == 2'h0,
            $past(REF_APPLIED) == 2'h1, $past(REF_APPLIED) == 2'h2};
    endproperty
    a_ref_decode: assert property (p_ref_decode)
        else $error("reference decode wrong");
    property p_ref_pin;
        !$past(SYS_RST) && REF_APPLIED == $past(REF_APPLIED)
            |-> REF_TO_PIN == (REF_APPLIED == 2'h3);
    endproperty
    a_ref_pin: assert property (p_ref_pin)
        else $error("reference pin link wrong");
    property p_power_on;
        wr_ctrl && PWDATA[7] |-> ##[1:2] CONVERTER_POWER;
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("converter did not power up");
    property p_power_off;
        wr_ctrl && !PWDATA[7] |-> ##[1:2] !CONVERTER_POWER && !CONVERTING;
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("disable did not stop converter");
    property p_conv_power;
        CONVERTING |-> CONVERTER_POWER;
    endproperty
    a_conv_power: assert property (p_conv_power)
        else $error("converting while powered down");
    property p_conv_min;
        $fell(CONVERTING) && CONVERTER_POWER |-> conv_len >= 12'd24;
    endproperty
    a_conv_min: assert property (p_conv_min)
        else $error("conversion ended too early");
    property p_conv_max;
        CONVERTING |-> conv_len < 12'd3300;
    endproperty
    a_conv_max: assert property (p_conv_max)
        else $error("conversion ran too long");
    property p_ack_clear;
        DONE_IRQ && IRQ_VECTOR_ACK && !CONVERTING |-> ##[1:2] !DONE_IRQ;
    endproperty
    a_ack_clear: assert property (p_ack_clear)
        else $error("vector ack did not clear flag");
    property p_hold;
        CONVERTING[*4] |-> $past(REF_APPLIED) == $past(REF_APPLIED, 2)
            && $past(POS_INPUT) == $past(POS_INPUT, 2);
    endproperty
    a_hold: assert property (p_hold)
        else $error("selection changed mid conversion");
    c_done: cover property (SAMPLE_STROBE);
    c_abort: cover property (wr_ctrl && !PWDATA[7] && CONVERTING);
    c_ack: cover property (DONE_IRQ && IRQ_VECTOR_ACK);
endmodule

bind adc_channel_reference_control adc_ctrl_sva i_sva (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK), .CONVERTER_POWER(CONVERTER_POWER),
    .CONVERTING(CONVERTING), .SAMPLE_STROBE(SAMPLE_STROBE),
    .REF_APPLIED(REF_APPLIED), .REF_SUPPLY_SEL(REF_SUPPLY_SEL),
    .REF_EXTERNAL_SEL(REF_EXTERNAL_SEL), .REF_INTERNAL_SEL(REF_INTERNAL_SEL),
    .REF_TO_PIN(REF_TO_PIN), .POS_INPUT(POS_INPUT), .DONE_IRQ(DONE_IRQ)
);

// file: testbench.sv
/*
 * self-checking bench for the converter control block.
 * assumes the defs header beside the design and apb without wait states.
 */
`timescale 1ns/1ns
`include "adc_ctrl_defs.vh"
module testbench;
    reg CLOCK, SYS_RST, PSEL, PENABLE, PWRITE, IRQ_VECTOR_ACK;
    reg [11:0] PADDR;
    reg [31:0] PWDATA;
    reg [9:0] CONV_RESULT;
    wire PREADY, PSLVERR, CONVERTER_POWER, CONVERTING, SAMPLE_STROBE;
    wire REF_SUPPLY_SEL, REF_EXTERNAL_SEL, REF_INTERNAL_SEL, REF_TO_PIN;
    wire DIFFERENTIAL, GAIN_20X, TEMP_SENSOR_EN, DONE_IRQ;
    wire [31:0] PRDATA;
    wire [1:0] REF_APPLIED;
    wire [3:0] POS_INPUT, NEG_INPUT;
    integer failures = 0, n_compared = 0, i, t0, cyc = 0, strobes = 0;
    logic [31:0] rd;
    logic [1:0] r;
    // mux byte, positive, negative, flags (differential, gain, sensor)
    logic [19:0] rows [0:16] = '{20'h00000, 20'h47700, 20'h88014,
        20'hc9016, 20'h0a034, 20'h2a304, 20'h51236, 20'h9f676, 20'h29106,
        20'h3f766, 20'h30324, 20'h20800, 20'h61900, 20'ha2a01, 20'h23006,
        20'h64334, 20'he7776};
    adc_channel_reference_control i_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA),
        .PSLVERR(PSLVERR), .CONV_RESULT(CONV_RESULT),
        .IRQ_VECTOR_ACK(IRQ_VECTOR_ACK), .CONVERTER_POWER(CONVERTER_POWER),
        .CONVERTING(CONVERTING), .SAMPLE_STROBE(SAMPLE_STROBE),
        .REF_APPLIED(REF_APPLIED), .REF_SUPPLY_SEL(REF_SUPPLY_SEL),
        .REF_EXTERNAL_SEL(REF_EXTERNAL_SEL),
        .REF_INTERNAL_SEL(REF_INTERNAL_SEL), .REF_TO_PIN(REF_TO_PIN),
        .POS_INPUT(POS_INPUT), .NEG_INPUT(NEG_INPUT),
        .DIFFERENTIAL(DIFFERENTIAL), .GAIN_20X(GAIN_20X),
        .TEMP_SENSOR_EN(TEMP_SENSOR_EN), .DONE_IRQ(DONE_IRQ));
    // 100 ns clock
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end
    // cycle and strobe counters
    always @(posedge CLOCK) begin
        cyc <= cyc + 1;
        strobes <= strobes + SAMPLE_STROBE;
    end
    task close_out;
        $display("compared %0d failed %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge CLOCK);
    endtask
    // one apb transfer, held until pready is seen
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do @(posedge CLOCK); while (PREADY !== 1'b1);
        rd = PRDATA;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task wait_strobe;
        while (SAMPLE_STROBE !== 1'b1) @(posedge CLOCK);
    endtask
    // hang guard
    initial begin
        #2000000;
        failures = failures + 1;
        close_out;
    end
    initial begin
        {SYS_RST, PSEL, PENABLE, PWRITE, IRQ_VECTOR_ACK} = 5'h10;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        CONV_RESULT = 10'h2a5;
        tick(8);
        SYS_RST <= 1'b0;
        // idle selection table
        for (i = 0; i < 17; i = i + 1) begin
            apb(1'b1, `ADDR_MUX_SELECT, {24'h0, rows[i][19:12]});
            tick(4);
            r = rows[i][19:18];
            chk("decode", {15'h0, rows[i][11:4], rows[i][2:0], r == 2'h0,
                r == 2'h1, r == 2'h2, r == 2'h3, r}, {15'h0, POS_INPUT,
                rows[i][2] ? NEG_INPUT : 4'h0, DIFFERENTIAL, GAIN_20X,
                TEMP_SENSOR_EN, REF_SUPPLY_SEL, REF_EXTERNAL_SEL,
                REF_INTERNAL_SEL, REF_TO_PIN, REF_APPLIED}); // all but NEG_INPUT on single-ended rows
            apb(1'b0, `ADDR_MUX_SELECT, 32'h0);
            chk("readback", {24'h0, rows[i][19:12]}, rd); // stored
        end
        // first conversion with a held selection change
        apb(1'b1, `ADDR_MUX_SELECT, 32'h0);
        apb(1'b1, `ADDR_CTRL_STATUS_A, 32'hc0);
        t0 = cyc;
        apb(1'b1, `ADDR_MUX_SELECT, 32'h49);
        tick(4);
        chk("held", 32'h0, {26'h0, REF_APPLIED, POS_INPUT}); // held
        apb(1'b0, `ADDR_CTRL_STATUS_A, 32'h0);
        chk("busy", 32'h1, {31'h0, rd[6]}); // start bit
        wait_strobe;
        chk("long", 32'h1, {31'h0, cyc - t0 >= 48 && cyc - t0 <= 58});
        tick(4);
        chk("applied", {20'h0, 2'h1, 4'h0, 4'h1, 2'h3}, {20'h0, REF_APPLIED,
            POS_INPUT, NEG_INPUT, GAIN_20X, CONVERTER_POWER});
        apb(1'b0, `ADDR_CTRL_STATUS_A, 32'h0);
        chk("status", 32'h90, rd); // done set
        apb(1'b0, `ADDR_RESULT, 32'h0);
        chk("result", 32'h2a5, rd); // result
        // second conversion, normal length, irq
        tick(26); // let the new differential pair settle
        apb(1'b1, `ADDR_CTRL_STATUS_A, 32'hd8);
        t0 = cyc;
        wait_strobe;
        chk("short", 32'h1, {31'h0, cyc - t0 >= 24 && cyc - t0 <= 34});
        tick(2);
        apb(1'b0, `ADDR_CTRL_STATUS_A, 32'h0);
        chk("irq status", 32'h99, {rd[31:1], DONE_IRQ}); // flag
        IRQ_VECTOR_ACK <= 1'b1;
        @(posedge CLOCK);
        IRQ_VECTOR_ACK <= 1'b0;
        tick(3);
        chk("ack", 32'h0, {31'h0, DONE_IRQ}); // cleared
        // abort mid conversion
        apb(1'b1, `ADDR_CTRL_STATUS_A, 32'hc0);
        i = strobes;
        tick(6);
        apb(1'b1, `ADDR_CTRL_STATUS_A, 32'h0);
        tick(60);
        chk("abort", 32'h0, {29'h0, CONVERTING, CONVERTER_POWER,
            strobes != i}); // no result
        apb(1'b0, `ADDR_CTRL_STATUS_A, 32'h0);
        chk("abort status", 32'h0, rd); // no flag
        // unmapped place reads zero
        apb(1'b1, 12'h3fc, 32'hff);
        apb(1'b0, 12'h3fc, 32'h0);
        chk("unmapped", 32'h0, {rd[31:1], rd[0] | PSLVERR});
        // reset after a mux write, with no conversion running
        apb(1'b1, `ADDR_MUX_SELECT, 32'hc5);
        SYS_RST <= 1'b1;
        tick(2);
        SYS_RST <= 1'b0;
        tick(3);
        chk("reset out", 32'h10, {27'h0, REF_SUPPLY_SEL, POS_INPUT});
        apb(1'b0, `ADDR_MUX_SELECT, 32'h0);
        chk("reset mux", 32'h0, rd);
        apb(1'b0, `ADDR_CTRL_STATUS_A, 32'h0);
        chk("reset ctrl", 32'h0, rd);
        close_out;
    end
endmodule
